// [hdl/supply_fault_supervisor.sv]
`timescale 1ns/100ps
module supply_fault_supervisor (
    input  wire logic                                  clk,
    input  wire logic                                  nrst,
    input  wire logic [supply_fault_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic [supply_fault_pkg::DATA_W-1:0]   regWrData,
    input  wire logic                                  regWr,
    input  wire logic                                  regRd,
    output logic      [supply_fault_pkg::DATA_W-1:0]   regRdData,
    input  wire logic                                  coreOkPin,
    input  wire logic                                  pumpOkPin,
    input  wire logic                                  modeSelPin,
    input  wire logic                                  pumpEnablePin,
    input  wire logic                                  faultActionPin,
    input  wire logic [supply_fault_pkg::HV_W-1:0]     ctlPins,
    output logic                                       faultPinOut,
    output logic                                       faultPinOe,
    output logic      [supply_fault_pkg::HV_W-1:0]     hvOut,
    output logic                                       pumpRun,
    output logic                                       sleepOut
);
    import supply_fault_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [HV_W-1:0]   stateBits;
        logic              sleepBit;
        logic              actionBit;
        logic              cmpOffBit;
        logic              pumpEnBit;
        logic              faultFlag;
        logic              armed;
        logic              pinOut;
        logic              pinOe;
        logic [HV_W-1:0]   hv;
        logic              pump;
        logic              sleep;
        logic [DATA_W-1:0] rdData;
    } main_st_t;

    localparam main_st_t ST_RST = '{
        stateBits: STATE_RST, sleepBit: BIT_RST, actionBit: BIT_RST,
        cmpOffBit: BIT_RST, pumpEnBit: BIT_RST, faultFlag: BIT_RST,
        armed: BIT_RST, pinOut: BIT_RST, pinOe: BIT_RST, hv: STATE_RST,
        pump: BIT_RST, sleep: BIT_RST, rdData: RDATA_RST};

    main_st_t st_r;
    main_st_t st_nxt;

    function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
        regHit = (a == off);
    endfunction : regHit

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [PIN_COUNT-1:0] pinsS;
    logic                 coreOkS;
    logic                 pumpOkS;
    logic                 serialMode;
    logic                 pumpEnEff;
    logic                 actionEff;
    logic                 pumpIgnore;
    logic                 coreFault;
    logic                 pumpFault;
    logic                 faultNow;
    logic                 shutdown;
    logic                 trip;
    logic                 stateWrite;
    logic                 ctlWrite;
    logic                 flagClear;

    // Comparators are asynchronous to clk
    pin_sync #(
        .WIDTH (PIN_COUNT)
    ) u_sync (
        .clk    (clk),
        .nrst   (nrst),
        .pinIn  ({ctlPins, faultActionPin, pumpEnablePin, modeSelPin,
                  pumpOkPin, coreOkPin}),
        .pinOut (pinsS)
    );

    assign coreOkS    = pinsS[PIN_CORE_OK];
    assign pumpOkS    = pinsS[PIN_PUMP_OK];
    // Mode pin low selects the serial register interface
    assign serialMode = !pinsS[PIN_MODE];

    // ==========================================================
    // Effective controls
    // ==========================================================
    assign pumpEnEff  = serialMode ? st_r.pumpEnBit : pinsS[PIN_PUMP_EN];
    assign actionEff  = serialMode ? st_r.actionBit : pinsS[PIN_ACTION];
    assign pumpIgnore = serialMode ? st_r.cmpOffBit
                                   : !pinsS[PIN_PUMP_EN];

    // ==========================================================
    // Fault detection
    // ==========================================================
    // Each supply is judged on its own, so a faulted one never masks the other
    assign coreFault = !coreOkS;
    assign pumpFault = !pumpOkS && !pumpIgnore;
    // Level OR: once armed, holds while the core supply or an unignored pump supply is down, no host action
    assign faultNow  = st_r.armed && (coreFault || pumpFault);
    assign trip      = faultNow && !actionEff;

    restart_latch u_restart (
        .clk        (clk),
        .nrst       (nrst),
        .trip       (trip),
        .pumpEnable (pumpEnEff),
        .shutdown   (shutdown)
    );

    // ==========================================================
    // Register writes
    // ==========================================================
    assign stateWrite = regWr && regHit(regAddr, STATE_OFF)
                        && regWrData[WR_PERMIT_BIT];
    assign ctlWrite   = regWr && regHit(regAddr, CONTROL_OFF)
                        && regWrData[WR_PERMIT_BIT];
    assign flagClear  = ctlWrite && !regWrData[FLAG_BIT];

    always_comb begin
        st_nxt = st_r;
        if (stateWrite) begin
            st_nxt.stateBits = regWrData[HV_W-1:0];
        end
        if (ctlWrite) begin
            st_nxt.sleepBit  = regWrData[SLEEP_BIT];
            st_nxt.actionBit = regWrData[ACTION_BIT];
            st_nxt.cmpOffBit = regWrData[CMP_OFF_BIT];
            st_nxt.pumpEnBit = regWrData[PUMP_EN_BIT];
        end
        // Arming needs the pump up too, unless its monitor is ignored
        if (coreOkS && (pumpOkS || pumpIgnore)) begin
            st_nxt.armed = 1'b1;
        end
        // A fault in the clearing cycle keeps the flag set
        st_nxt.faultFlag = faultNow || (st_r.faultFlag && !flagClear);
        st_nxt.pinOut    = 1'b0;
        st_nxt.pinOe     = faultNow;
        st_nxt.pump      = pumpEnEff && !st_r.sleepBit && !shutdown;
        if (shutdown) begin
            st_nxt.hv = '0;
        end else if (serialMode) begin
            st_nxt.hv = st_r.stateBits;
        end else begin
            st_nxt.hv = pinsS[PIN_CTL_LO +: HV_W];
        end
        st_nxt.sleep = serialMode && st_r.sleepBit;
        // Unmapped addresses and idle cycles read zero
        st_nxt.rdData = '0;
        if (regRd && regHit(regAddr, STATE_OFF)) begin
            st_nxt.rdData[HV_W-1:0] = st_r.stateBits;
        end else if (regRd && regHit(regAddr, CONTROL_OFF)) begin
            st_nxt.rdData[FLAG_BIT]    = st_r.faultFlag;
            st_nxt.rdData[SLEEP_BIT]   = st_r.sleepBit;
            st_nxt.rdData[ACTION_BIT]  = st_r.actionBit;
            st_nxt.rdData[CMP_OFF_BIT] = st_r.cmpOffBit;
            st_nxt.rdData[PUMP_EN_BIT] = st_r.pumpEnBit;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData   = st_r.rdData;
    assign faultPinOut = st_r.pinOut;
    assign faultPinOe  = st_r.pinOe;
    assign hvOut       = st_r.hv;
    assign pumpRun     = st_r.pump;
    assign sleepOut    = st_r.sleep;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_pin_not_before_arm: assert property (
        !st_r.armed |-> !st_r.pinOe)
        else $error("fault pin pulled before arming");

    a_pin_pulls_flag: assert property (
        st_r.pinOe |-> st_r.faultFlag && !st_r.pinOut)
        else $error("fault pin low without flag");

    a_core_drop_fault: assert property (
        st_r.armed && !coreOkS |=> st_r.pinOe && st_r.faultFlag)
        else $error("core drop not reported");

    a_pump_fault_holds: assert property (
        st_r.armed && !pumpIgnore && !pumpOkS |=> st_r.pinOe)
        else $error("pump drop not reported");

    a_pump_ignored: assert property (
        st_r.armed && coreOkS && pumpIgnore |=> !st_r.pinOe)
        else $error("ignored pump monitor reported");

    a_pin_release: assert property (
        st_r.armed && coreOkS && pumpOkS |=> !st_r.pinOe)
        else $error("fault pin not released");

    a_flag_sticky: assert property (
        st_r.faultFlag && !flagClear |=> st_r.faultFlag)
        else $error("fault flag lost without clear");

    a_flag_clears: assert property (
        flagClear && !faultNow |=> !st_r.faultFlag)
        else $error("fault flag not cleared by write");

    a_shut_outputs: assert property (
        trip |=> shutdown ##1 (st_r.hv == '0) && !st_r.pump)
        else $error("shutdown did not clear outputs");

    a_report_only: assert property (
        !shutdown && faultNow && actionEff |=> !shutdown)
        else $error("report-only fault shut down");

    a_restart_seq: assert property (
        shutdown && !pumpEnEff ##1 pumpEnEff && !trip |=> !shutdown)
        else $error("no restart after enable toggle");

    a_no_permit: assert property (
        regWr && !regWrData[WR_PERMIT_BIT] |=> $stable(st_r.stateBits)
            && $stable(st_r.pumpEnBit))
        else $error("write without permit changed a register");

    // ==========================================================
    // Arming, reporting, register and output assertions
    // ==========================================================
    a_pin_open_drain: assert property (
        st_r.pinOe
        |-> !faultPinOut)
        else $error("fault pin driven high");

    a_fault_sets_flag: assert property (
        faultNow
        |=> st_r.faultFlag)
        else $error("fault did not set flag");

    a_flag_readback: assert property (
        regRd && regHit(regAddr, CONTROL_OFF)
        |=> st_r.rdData[FLAG_BIT] == $past(st_r.faultFlag))
        else $error("flag bit not read back");

    a_rd_idle_zero: assert property (
        !regRd
        |=> st_r.rdData == '0)
        else $error("read data not zero when idle");

    a_unarmed_quiet: assert property (
        !st_r.armed && !st_r.faultFlag
        |=> !st_r.faultFlag)
        else $error("flag set before arming");

    a_arm_needs_core: assert property (
        !st_r.armed && !coreOkS
        |=> !st_r.armed)
        else $error("armed with core supply low");

    // Arming is one way: a brownout must not hide the next fault
    a_arm_sticks: assert property (
        st_r.armed
        |=> st_r.armed)
        else $error("monitoring disarmed without reset");

    a_parallel_ignore: assert property (
        !serialMode && !pinsS[PIN_PUMP_EN] && st_r.armed && coreOkS
        |=> !st_r.pinOe)
        else $error("pump monitor used with enable pin low");

    a_core_keeps_fault: assert property (
        st_r.armed && !coreOkS && pumpOkS
        |=> st_r.pinOe)
        else $error("fault released with core supply low");

    a_shut_holds: assert property (
        $past(shutdown)
        |-> (st_r.hv == '0) && !st_r.pump)
        else $error("outputs active during shutdown");

    a_shut_needs_trip: assert property (
        !shutdown && !trip
        |=> !shutdown)
        else $error("shutdown without a trip");

    a_hv_follows_state: assert property (
        serialMode && !shutdown
        |=> st_r.hv == $past(st_r.stateBits))
        else $error("switch outputs differ from state bits");

    a_pump_follows_bit: assert property (
        serialMode && st_r.pumpEnBit && !st_r.sleepBit && !shutdown
        |=> st_r.pump)
        else $error("pump off with enable bit set");

    a_pump_off_disabled: assert property (
        !pumpEnEff
        |=> !st_r.pump)
        else $error("pump on with enable low");

    a_ctl_write_lands: assert property (
        ctlWrite && regWrData[PUMP_EN_BIT]
        |=> st_r.pumpEnBit)
        else $error("permitted control write lost");

    a_state_write_lands: assert property (
        stateWrite && regWrData[0]
        |=> st_r.stateBits[0])
        else $error("permitted state write lost");

    c_core_fault:   cover property (st_r.armed && !coreOkS ##1 st_r.pinOe);
    c_shutdown:     cover property (trip ##1 shutdown);
    c_restart:      cover property (shutdown ##1 !pumpEnEff ##[1:4] !shutdown);
    c_flag_cleared: cover property (st_r.faultFlag ##1 flagClear ##1 !st_r.faultFlag);
    c_report_only:  cover property (faultNow && actionEff ##1 st_r.pinOe && !shutdown);

endmodule : supply_fault_supervisor

// [hdl/supply_fault_pkg.sv]
package supply_fault_pkg;

    // ==========================================================
    // Register port
    // ==========================================================
    localparam int          ADDR_W        = 2;
    localparam int          DATA_W        = 8;
    localparam logic [1:0]  STATE_OFF     = 2'h0;
    localparam logic [1:0]  CONTROL_OFF   = 2'h1;

    // ==========================================================
    // Control register fields and state register width
    // ==========================================================
    localparam int          WR_PERMIT_BIT = 7;
    localparam int          FLAG_BIT      = 6;
    localparam int          SLEEP_BIT     = 5;
    localparam int          ACTION_BIT    = 4;
    localparam int          CMP_OFF_BIT   = 3;
    localparam int          PUMP_EN_BIT   = 1;
    localparam int          HV_W          = 4;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic [3:0]  STATE_RST     = 4'h0;
    localparam logic        BIT_RST       = 1'b0;
    localparam logic [7:0]  RDATA_RST     = 8'h00;

    // ==========================================================
    // Synchronised pin vector
    // ==========================================================
    localparam int          SYNC_STAGES   = 2;
    localparam int          PIN_COUNT     = 9;
    localparam int          PIN_CORE_OK   = 0;
    localparam int          PIN_PUMP_OK   = 1;
    localparam int          PIN_MODE      = 2;
    localparam int          PIN_PUMP_EN   = 3;
    localparam int          PIN_ACTION    = 4;
    localparam int          PIN_CTL_LO    = 5;

    // ==========================================================
    // Shutdown and restart states
    // ==========================================================
    typedef enum logic [1:0] {
        RUNNING   = 2'b00,
        SHUT_HIGH = 2'b01,
        SHUT_LOW  = 2'b10
    } shut_state_t;

endpackage : supply_fault_pkg

// [hdl/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 9
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    import supply_fault_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_st_t;

    sync_st_t st_r;
    sync_st_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt        = st_r;
        st_nxt.first  = pinIn;
        st_nxt.second = st_r.first;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pinOut = st_r.second;

endmodule : pin_sync

// [hdl/restart_latch.sv]
`timescale 1ns/100ps
module restart_latch (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic trip,
    input  wire logic pumpEnable,
    output logic      shutdown
);
    import supply_fault_pkg::*;

    typedef struct packed {
        shut_state_t state;
    } latch_st_t;

    latch_st_t st_r;
    latch_st_t st_nxt;

    // A new trip always wins over a restart in the same cycle
    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            RUNNING: begin
                if (trip) begin
                    st_nxt.state = SHUT_HIGH;
                end
            end
            SHUT_HIGH: begin
                if (!pumpEnable) begin
                    st_nxt.state = SHUT_LOW;
                end
            end
            SHUT_LOW: begin
                if (pumpEnable && !trip) begin
                    st_nxt.state = RUNNING;
                end
            end
            default: begin
                st_nxt.state = SHUT_HIGH;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r.state <= RUNNING;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign shutdown = (st_r.state != RUNNING);

endmodule : restart_latch

// [tb/host_model.sv]
`timescale 1ns/100ps
module host_model (
    input  wire logic                                clk,
    output logic      [supply_fault_pkg::ADDR_W-1:0] regAddr,
    output logic      [supply_fault_pkg::DATA_W-1:0] regWrData,
    output logic                                     regWr,
    output logic                                     regRd,
    input  wire logic [supply_fault_pkg::DATA_W-1:0] regRdData,
    output logic                                     modeSelPin,
    output logic                                     pumpEnablePin,
    output logic                                     faultActionPin,
    output logic      [supply_fault_pkg::HV_W-1:0]   ctlPins
);
    import supply_fault_pkg::*;

    // ==========================================================
    // Idle levels
    // ==========================================================
    initial begin
        regAddr        = '0;
        regWrData      = '0;
        regWr          = 1'b0;
        regRd          = 1'b0;
        modeSelPin     = 1'b0;
        pumpEnablePin  = 1'b0;
        faultActionPin = 1'b0;
        ctlPins        = '0;
    end

    // ==========================================================
    // Register port cycles
    // ==========================================================
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr     <= 1'b0;
        // Released data must not look like a held value
        regWrData <= ~d;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd

    // ==========================================================
    // Parallel configuration pins
    // ==========================================================
    task automatic pins(input logic m, input logic e, input logic a, input logic [HV_W-1:0] c);
        @(posedge clk);
        modeSelPin     <= m;
        pumpEnablePin  <= e;
        faultActionPin <= a;
        ctlPins        <= c;
    endtask : pins
endmodule : host_model

// [tb/supply_fault_supervisor_tb_top.sv]
`timescale 1ns/100ps
module supply_fault_supervisor_tb_top;
    import supply_fault_pkg::*;

    logic              clk = 1'b0;
    logic              nrst;
    logic              coreOkPin;
    logic              pumpOkPin;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic              regWr;
    logic              regRd;
    logic [DATA_W-1:0] regRdData;
    logic              modeSelPin;
    logic              pumpEnablePin;
    logic              faultActionPin;
    logic [HV_W-1:0]   ctlPins;
    logic              faultPinOut;
    logic              faultPinOe;
    logic [HV_W-1:0]   hvOut;
    logic              pumpRun;
    logic              sleepOut;
    int                errorCnt    = 0;
    int                checksDone  = 0;
    // Board pull-up on the open-drain fault line
    wire               faultLine = faultPinOe ? faultPinOut : 1'b1;

    always #10 clk = ~clk;

    supply_fault_supervisor i_supply_fault_supervisor (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .coreOkPin(coreOkPin), .pumpOkPin(pumpOkPin), .modeSelPin(modeSelPin),
        .pumpEnablePin(pumpEnablePin), .faultActionPin(faultActionPin),
        .ctlPins(ctlPins), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe),
        .hvOut(hvOut), .pumpRun(pumpRun), .sleepOut(sleepOut)
    );

    host_model i_host_model (
        .clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .modeSelPin(modeSelPin),
        .pumpEnablePin(pumpEnablePin), .faultActionPin(faultActionPin),
        .ctlPins(ctlPins)
    );

    // ==========================================================
    // Checks and helpers
    // ==========================================================
    task automatic summarize();
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic chkReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        i_host_model.rd(a, d);
        checksDone++;
        if (d !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t reg %0d read %h want %h", $time, a, d, exp);
        end
    endtask : chkReg

    // Expected vector is fault line, pump run, switch outputs
    task automatic chkPin(input logic [5:0] exp);
        checksDone++;
        if ({faultLine, pumpRun, hvOut} !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t pins %h want %h", $time, {faultLine, pumpRun, hvOut}, exp);
        end
    endtask : chkPin

    task automatic chkSleep(input logic exp);
        checksDone++;
        if (sleepOut !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t sleep %b want %b", $time, sleepOut, exp);
        end
    endtask : chkSleep

    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitCyc

    // Comparator change needs three edges to reach the fault line, four for a shutdown to clear the outputs
    task automatic sup(input logic c, input logic p);
        @(posedge clk);
        coreOkPin <= c;
        pumpOkPin <= p;
        waitCyc(5);
    endtask : sup

    initial begin
        #40000;
        errorCnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        nrst      = 1'b0;
        coreOkPin = 1'b0;
        pumpOkPin = 1'b0;
        // Reset is applied on a clock edge too, so state is known at the first check
        waitCyc(1);
        chkPin(6'h20);
        repeat (15) @(posedge clk);
        nrst <= 1'b1;
        chkReg(CONTROL_OFF, 8'h00);
        chkReg(STATE_OFF, 8'h00);
        waitCyc(6);
        chkPin(6'h20);
        sup(1'b1, 1'b1);
        i_host_model.wr(STATE_OFF, 8'h05);
        chkReg(STATE_OFF, 8'h00);
        i_host_model.wr(STATE_OFF, 8'h85);
        i_host_model.wr(CONTROL_OFF, 8'h82);
        chkReg(STATE_OFF, 8'h05);
        waitCyc(2);
        chkPin(6'h35);
        sup(1'b0, 1'b1);
        chkPin(6'h00);
        chkReg(CONTROL_OFF, 8'h42);
        sup(1'b1, 1'b1);
        chkPin(6'h20);
        chkReg(CONTROL_OFF, 8'h42);
        i_host_model.wr(CONTROL_OFF, 8'h80);
        i_host_model.wr(CONTROL_OFF, 8'h82);
        waitCyc(3);
        chkPin(6'h35);
        chkReg(CONTROL_OFF, 8'h02);
        i_host_model.wr(CONTROL_OFF, 8'h92);
        sup(1'b0, 1'b0);
        chkPin(6'h15);
        sup(1'b1, 1'b0);
        chkPin(6'h15);
        sup(1'b1, 1'b1);
        chkPin(6'h35);
        i_host_model.wr(CONTROL_OFF, 8'h9a);
        sup(1'b1, 1'b0);
        chkPin(6'h35);
        chkReg(CONTROL_OFF, 8'h1a);
        i_host_model.wr(CONTROL_OFF, 8'hba);
        waitCyc(2);
        chkSleep(1'b1);
        chkPin(6'h25);
        chkReg(CONTROL_OFF, 8'h3a);
        i_host_model.wr(CONTROL_OFF, 8'h9a);
        waitCyc(2);
        chkSleep(1'b0);
        chkPin(6'h35);
        i_host_model.pins(1'b1, 1'b0, 1'b1, 4'ha);
        waitCyc(5);
        chkPin(6'h2a);
        i_host_model.pins(1'b1, 1'b1, 1'b1, 4'ha);
        waitCyc(5);
        chkPin(6'h1a);
        i_host_model.pins(1'b1, 1'b1, 1'b0, 4'ha);
        waitCyc(5);
        chkPin(6'h00);
        // Second reset in mid-run: registers clear and the unrisen pump keeps it unarmed
        nrst <= 1'b0;
        waitCyc(2);
        nrst <= 1'b1;
        chkReg(CONTROL_OFF, 8'h00);
        chkReg(STATE_OFF, 8'h00);
        waitCyc(4);
        chkPin(6'h3a);
        summarize();
    end
endmodule : supply_fault_supervisor_tb_top
